/* File: src/ssr_pkg.sv */
package ssr_pkg;
    // Setting register numbers on the parameter port
    localparam logic [15:0] REG_FREQ_SRC  = 16'h0180;
    localparam logic [15:0] REG_RUN_SRC   = 16'h0181;
    localparam logic [15:0] REG_STATUS    = 16'h0020;
    localparam logic [15:0] REG_REF_BASE  = 16'h0280;
    localparam logic [15:0] REG_MF_BASE   = 16'h0400;
    localparam logic [15:0] REG_AN3_FUNC  = 16'h0410;
    localparam logic [15:0] REG_AN2_FUNC  = 16'h0411;
    // Reset values
    localparam logic [15:0] FREQ_SRC_RST  = 16'h0001;
    localparam logic [15:0] RUN_SRC_RST   = 16'h0001;
    localparam logic [15:0] AN_UNUSED     = 16'h001f;
    localparam logic [15:0] AN2_FUNC_RST  = 16'h0000;
    // Upper legal codes
    localparam logic [15:0] FREQ_SRC_MAX  = 16'h0004;
    localparam logic [15:0] RUN_SRC_MAX   = 16'h0003;
    // Frequency source codes
    localparam logic [15:0] FSRC_ANALOG   = 16'h0001;
    // Analog function codes
    localparam logic [15:0] AN_AUX_ONE    = 16'h0002;
    localparam logic [15:0] AN_AUX_TWO    = 16'h0003;
    // Multi-function input codes
    localparam logic [7:0]  MF_THREE_WIRE = 8'h00;
    localparam logic [7:0]  MF_STEP_ONE   = 8'h03;
    localparam logic [7:0]  MF_STEP_TWO   = 8'h04;
    localparam logic [7:0]  MF_STEP_THREE = 8'h05;
    localparam logic [7:0]  MF_JOG       = 8'h06;
    localparam logic [7:0]  MF_UNUSED     = 8'h0f;
    // Factory slots: S3..S12 map to slots 0..9
    localparam int          SLOT_STEP_ONE   = 2;
    localparam int          SLOT_STEP_TWO   = 3;
    localparam int          SLOT_JOG        = 4;
    localparam int          SLOT_STEP_THREE = 6;
    localparam int          SLOT_INIT_DIR   = 0;
    // Stored reference slots
    localparam int          NUM_REFS = 17;
    localparam int          JOG_SLOT = 16;
    localparam logic [4:0]  JOG_STEP = 5'h09;
    localparam logic [4:0]  STEP_BASE = 5'h01;
    // Run command sources
    typedef enum logic [1:0] {
        SSR_SRC_KEYPAD,
        SSR_SRC_TERMINAL,
        SSR_SRC_SERIAL,
        SSR_SRC_OPTION
    } ssr_src_e;
endpackage

/* File: src/ssr_cmd_select.sv */
`timescale 1ns/100ps
// Contract
// - Nine steps: eight stored plus jog
// - Step inputs form binary index, refs 1-8
// - All off selects reference one or master
// - Step one: analog one when source is 1
// - Step two: analog three when function 2
// - Step three: analog two when function 3
// - Jog select overrides all step inputs
// - Inputs assignable by code, factory defaults set
// - Refuse equal analog two and three functions
// - Run source 0-3, factory value 1
// - Keypad source takes keypad run commands
// - Two-wire unless direction function assigned
// - Two-wire: run while forward or reverse alone on, both on is stop
// - Code 0 enables three-wire with direction input
// - Three-wire initialize sets input three direction
// - Three-wire run pulse latched internally
// - Frequency source accepts 0 to 4
module ssr_cmd_select #(
    parameter int NUM_MF = 10,
    parameter int DW     = 16
) (
    input  wire logic          clk_sys_i,
    input  wire logic          nrst_i,
    input  wire logic          par_wr_i,
    input  wire logic [15:0]   par_addr_i,
    input  wire logic [15:0]   par_wdata_i,
    output logic      [15:0]   par_rdata_o,
    input  wire logic          initialize_select_i,
    input  wire logic          forward_run_pin_i,
    input  wire logic          reverse_stop_pin_i,
    input  wire logic [NUM_MF-1:0] mf_pin_i,
    input  wire logic [DW-1:0] first_analog_input_i,
    input  wire logic [DW-1:0] second_analog_input_i,
    input  wire logic [DW-1:0] third_analog_input_i,
    input  wire logic          key_run_i,
    input  wire logic          key_stop_i,
    input  wire logic          key_jog_i,
    input  wire logic          key_rev_i,
    input  wire logic          serial_run_i,
    input  wire logic          serial_rev_i,
    input  wire logic          option_run_i,
    input  wire logic          option_rev_i,
    output logic [DW-1:0]      sel_freq_o,
    output logic [4:0]         sel_step_o,
    output logic               run_fwd_o,
    output logic               run_rev_o,
    output logic               three_wire_o
);
    logic [15:0]   freq_src_r;
    logic [15:0]   run_src_r;
    logic [15:0]   an3_func_r;
    logic [15:0]   an2_func_r;
    logic [DW-1:0] ref_mem [ssr_pkg::NUM_REFS];
    logic [7:0]    mf_func_r [NUM_MF];
    logic          key_latch_r;
    logic          wire3_latch_r;
    logic [DW-1:0] sel_freq_r;
    logic [4:0]    sel_step_r;
    logic          run_fwd_r;
    logic          run_rev_r;
    logic          three_wire_r;
    logic [15:0]   par_rdata_r;

    // Per-input function decode
    logic [NUM_MF-1:0] hit_s1;
    logic [NUM_MF-1:0] hit_s2;
    logic [NUM_MF-1:0] hit_s3;
    logic [NUM_MF-1:0] hit_jog;
    logic [NUM_MF-1:0] hit_dir;
    logic [NUM_MF-1:0] is_dir;
    genvar g;
    generate
        for (g = 0; g < NUM_MF; g++) begin : g_mf
            assign hit_s1[g]  = mf_pin_i[g] && mf_func_r[g] == ssr_pkg::MF_STEP_ONE;
            assign hit_s2[g]  = mf_pin_i[g] && mf_func_r[g] == ssr_pkg::MF_STEP_TWO;
            assign hit_s3[g]  = mf_pin_i[g] && mf_func_r[g] == ssr_pkg::MF_STEP_THREE;
            assign hit_jog[g] = mf_pin_i[g] && mf_func_r[g] == ssr_pkg::MF_JOG;
            assign is_dir[g]  = mf_func_r[g] == ssr_pkg::MF_THREE_WIRE;
            assign hit_dir[g] = mf_pin_i[g] && is_dir[g];
        end
    endgenerate

    // Step index and reference selection, evaluated every cycle
    wire         step_one_pin   = |hit_s1;
    wire         step_two_pin   = |hit_s2;
    wire         step_three_pin = |hit_s3;
    wire         src_keypad     = run_src_r[1:0] == ssr_pkg::SSR_SRC_KEYPAD;
    wire         jog_on         = (|hit_jog) || (src_keypad && key_jog_i);
    wire [2:0]   step_idx       = {step_three_pin, step_two_pin, step_one_pin};
    wire [4:0]   step_nxt       = jog_on ? ssr_pkg::JOG_STEP
                                         : 5'({2'h0, step_idx}) + ssr_pkg::STEP_BASE;
    wire         an1_sel = freq_src_r == ssr_pkg::FSRC_ANALOG;
    wire         an3_sel = an3_func_r == ssr_pkg::AN_AUX_ONE;
    wire         an2_sel = an2_func_r == ssr_pkg::AN_AUX_TWO;
    wire [DW-1:0] stored = ref_mem[step_idx];
    wire [DW-1:0] freq_nxt =
        jog_on                      ? ref_mem[ssr_pkg::JOG_SLOT] :
        (step_idx == 3'h0 && an1_sel) ? first_analog_input_i :
        (step_idx == 3'h1 && an3_sel) ? third_analog_input_i :
        (step_idx == 3'h2 && an2_sel) ? second_analog_input_i : stored;

    // Run command decode
    wire three_wire = |is_dir;
    wire dir_rev    = |hit_dir;
    // Three-wire: run pin is a run pulse, stop pin closed means no stop
    wire w3_set   = forward_run_pin_i && reverse_stop_pin_i;
    wire w3_clr   = !reverse_stop_pin_i || !three_wire;
    wire w3_nxt   = w3_clr ? 1'b0 : (w3_set ? 1'b1 : wire3_latch_r);
    wire w3_run   = w3_set || wire3_latch_r;
    // Two-wire: both pins on counts as stop
    wire w2_fwd   = forward_run_pin_i && !reverse_stop_pin_i;
    wire w2_rev   = reverse_stop_pin_i && !forward_run_pin_i;
    wire term_fwd = three_wire ? (w3_run && reverse_stop_pin_i && !dir_rev) : w2_fwd;
    wire term_rev = three_wire ? (w3_run && reverse_stop_pin_i && dir_rev) : w2_rev;
    // Keypad: run key latches, stop key wins, jog key runs while held
    wire key_nxt  = src_keypad && !key_stop_i && (key_run_i || key_latch_r);
    wire key_go   = (key_run_i || key_latch_r || key_jog_i) && !key_stop_i;
    logic run_on;
    logic run_back;
    always_comb begin
        run_on   = 1'b0;
        run_back = 1'b0;
        case (ssr_pkg::ssr_src_e'(run_src_r[1:0]))
            ssr_pkg::SSR_SRC_KEYPAD: begin
                run_on   = key_go;
                run_back = key_rev_i;
            end
            ssr_pkg::SSR_SRC_TERMINAL: begin
                run_on   = term_fwd || term_rev;
                run_back = term_rev;
            end
            ssr_pkg::SSR_SRC_SERIAL: begin
                run_on   = serial_run_i;
                run_back = serial_rev_i;
            end
            ssr_pkg::SSR_SRC_OPTION: begin
                run_on   = option_run_i;
                run_back = option_rev_i;
            end
            default: begin
                run_on   = 1'b0;
                run_back = 1'b0;
            end
        endcase
    end

    // Parameter port write qualification
    wire wr_fsrc = par_wr_i && par_addr_i == ssr_pkg::REG_FREQ_SRC
                   && par_wdata_i <= ssr_pkg::FREQ_SRC_MAX;
    wire wr_rsrc = par_wr_i && par_addr_i == ssr_pkg::REG_RUN_SRC
                   && par_wdata_i <= ssr_pkg::RUN_SRC_MAX;
    wire wr_an3  = par_wr_i && par_addr_i == ssr_pkg::REG_AN3_FUNC
                   && par_wdata_i != an2_func_r;
    wire wr_an2  = par_wr_i && par_addr_i == ssr_pkg::REG_AN2_FUNC
                   && par_wdata_i != an3_func_r;
    wire [15:0] ref_off = par_addr_i - ssr_pkg::REG_REF_BASE;
    wire [15:0] mf_off  = par_addr_i - ssr_pkg::REG_MF_BASE;
    wire ref_hit = par_addr_i >= ssr_pkg::REG_REF_BASE
                   && ref_off < 16'(ssr_pkg::NUM_REFS);
    wire mf_hit  = par_addr_i >= ssr_pkg::REG_MF_BASE && mf_off < 16'(NUM_MF);

    // Read-back mux, unmapped numbers read zero
    wire [15:0] status = {11'h0, three_wire_r, key_latch_r, wire3_latch_r,
                          run_rev_r, run_fwd_r};
    wire [15:0] rd_nxt =
        par_addr_i == ssr_pkg::REG_FREQ_SRC ? freq_src_r :
        par_addr_i == ssr_pkg::REG_RUN_SRC  ? run_src_r :
        par_addr_i == ssr_pkg::REG_AN3_FUNC ? an3_func_r :
        par_addr_i == ssr_pkg::REG_AN2_FUNC ? an2_func_r :
        par_addr_i == ssr_pkg::REG_STATUS   ? status :
        ref_hit ? 16'(ref_mem[ref_off[4:0]]) :
        mf_hit  ? {8'h0, mf_func_r[mf_off[3:0]]} : 16'h0000;

    // Source and analog function settings
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            freq_src_r <= ssr_pkg::FREQ_SRC_RST;
            run_src_r  <= ssr_pkg::RUN_SRC_RST;
            an3_func_r <= ssr_pkg::AN_UNUSED;
            an2_func_r <= ssr_pkg::AN2_FUNC_RST;
        end else begin
            if (wr_fsrc) freq_src_r <= par_wdata_i;
            if (wr_rsrc) run_src_r <= par_wdata_i;
            if (wr_an3) an3_func_r <= par_wdata_i;
            if (wr_an2) an2_func_r <= par_wdata_i;
        end
    end

    // Stored references, no reset needed for the data words
    always_ff @(posedge clk_sys_i) begin
        if (par_wr_i && ref_hit) ref_mem[ref_off[4:0]] <= par_wdata_i[DW-1:0];
    end

    // Input function table with factory placement
    generate
        for (g = 0; g < NUM_MF; g++) begin : g_func
            localparam logic [7:0] DEF =
                g == ssr_pkg::SLOT_STEP_ONE   ? ssr_pkg::MF_STEP_ONE :
                g == ssr_pkg::SLOT_STEP_TWO   ? ssr_pkg::MF_STEP_TWO :
                g == ssr_pkg::SLOT_STEP_THREE ? ssr_pkg::MF_STEP_THREE :
                g == ssr_pkg::SLOT_JOG        ? ssr_pkg::MF_JOG : ssr_pkg::MF_UNUSED;
            always_ff @(posedge clk_sys_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    mf_func_r[g] <= DEF;
                end else if (initialize_select_i && g == ssr_pkg::SLOT_INIT_DIR) begin
                    mf_func_r[g] <= ssr_pkg::MF_THREE_WIRE;
                end else if (par_wr_i && mf_hit && mf_off[3:0] == 4'(g)) begin
                    mf_func_r[g] <= par_wdata_i[7:0];
                end
            end
        end
    endgenerate

    // Latches and registered outputs
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            key_latch_r   <= 1'b0;
            wire3_latch_r <= 1'b0;
            sel_freq_r    <= '0;
            sel_step_r    <= ssr_pkg::STEP_BASE;
            run_fwd_r     <= 1'b0;
            run_rev_r     <= 1'b0;
            three_wire_r  <= 1'b0;
            par_rdata_r   <= 16'h0000;
        end else begin
            key_latch_r   <= key_nxt;
            wire3_latch_r <= w3_nxt;
            sel_freq_r    <= freq_nxt;
            sel_step_r    <= step_nxt;
            run_fwd_r     <= run_on && !run_back;
            run_rev_r     <= run_on && run_back;
            three_wire_r  <= three_wire;
            par_rdata_r   <= rd_nxt;
        end
    end

    assign sel_freq_o   = sel_freq_r;
    assign sel_step_o   = sel_step_r;
    assign run_fwd_o    = run_fwd_r;
    assign run_rev_o    = run_rev_r;
    assign three_wire_o = three_wire_r;
    assign par_rdata_o  = par_rdata_r;

    // Checks
    jog_priority_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        jog_on |=> sel_step_o == ssr_pkg::JOG_STEP
                   && sel_freq_o == $past(ref_mem[ssr_pkg::JOG_SLOT]))
        else $error("jog not selected");
    step_index_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !jog_on |=> sel_step_o == 5'($past(step_idx)) + ssr_pkg::STEP_BASE)
        else $error("step index wrong");
    step_one_an_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (!jog_on && step_idx == 3'h0 && an1_sel)
        |=> sel_freq_o == $past(first_analog_input_i))
        else $error("analog one not used");
    step_two_an_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (!jog_on && step_idx == 3'h1)
        |=> sel_freq_o == ($past(an3_sel) ? $past(third_analog_input_i) : $past(ref_mem[1])))
        else $error("step two source wrong");
    step_three_an_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (!jog_on && step_idx == 3'h2 && an2_sel)
        |=> sel_freq_o == $past(second_analog_input_i))
        else $error("analog two not used");
    an_func_diff_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        an3_func_r != an2_func_r)
        else $error("analog functions equal");
    run_src_range_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        run_src_r <= ssr_pkg::RUN_SRC_MAX && freq_src_r <= ssr_pkg::FREQ_SRC_MAX)
        else $error("source out of range");
    two_wire_fwd_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (run_src_r == ssr_pkg::RUN_SRC_RST && !three_wire && w2_fwd) |=> run_fwd_o && !run_rev_o)
        else $error("two-wire forward lost");
    latch_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (three_wire && w3_set ##1 (three_wire && reverse_stop_pin_i)[*2])
        |-> wire3_latch_r)
        else $error("run pulse not held");
    stop_clear_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (three_wire && !reverse_stop_pin_i) |=> !wire3_latch_r)
        else $error("stop did not clear");
    init_dir_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        initialize_select_i |=> three_wire ##1 three_wire_o)
        else $error("initialize missed");
    step_one_ref_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (!jog_on && step_idx == 3'h0 && !an1_sel)
        |=> sel_freq_o == $past(ref_mem[0]))
        else $error("reference one not used");
    step_three_ref_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (!jog_on && step_idx == 3'h2 && !an2_sel)
        |=> sel_freq_o == $past(ref_mem[2]))
        else $error("reference three not used");
    two_wire_rev_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (run_src_r == ssr_pkg::RUN_SRC_RST && !three_wire && w2_rev)
        |=> run_rev_o && !run_fwd_o)
        else $error("two-wire reverse lost");
    keypad_stop_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (src_keypad && key_stop_i) |=> !run_fwd_o && !run_rev_o && !key_latch_r)
        else $error("keypad stop ignored");
    three_wire_dir_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (run_src_r == ssr_pkg::RUN_SRC_RST && three_wire && wire3_latch_r
         && reverse_stop_pin_i && dir_rev) |=> run_rev_o && !run_fwd_o)
        else $error("three-wire reverse lost");
endmodule

/* File: tb/ssr_contact_model.sv */
`timescale 1ns/100ps
// Contact side: a run request closes the run contact for a minimum hold time
module ssr_contact_model #(
    parameter int HOLD_CYC = 8
) (
    input  wire logic clk_sys_i,
    input  wire logic run_req_i,
    input  wire logic run_lvl_i,
    input  wire logic stop_lvl_i,
    output logic      forward_run_pin_o,
    output logic      reverse_stop_pin_o
);
    int hold_cnt = 0;
    // Hold counter, stepped at the rising edge so the bench request is seen cleanly
    always @(posedge clk_sys_i) begin
        if (run_req_i)
            hold_cnt <= HOLD_CYC;
        else if (hold_cnt > 0)
            hold_cnt <= hold_cnt - 1;
    end
    // Contact levels seen by the drive
    assign forward_run_pin_o  = run_lvl_i | (hold_cnt > 0);
    assign reverse_stop_pin_o = stop_lvl_i;
endmodule

/* File: tb/ssr_cmd_select_tb.sv */
`timescale 1ns/100ps
module ssr_cmd_select_tb;
    localparam int HOLD = 8;
    logic        clk_sys_i = 0, nrst_i = 0, par_wr = 0, init_sel = 0;
    logic [15:0] par_addr = '0, par_wdata = '0, par_rdata;
    logic [15:0] a1 = 16'h0a01, a2 = 16'h0a02, a3 = 16'h0a03, sel_freq;
    logic [9:0]  mf = '0;
    logic        run_req = 0, run_lvl = 0, stop_lvl = 0, fwd_pin, rev_pin;
    logic        key_run = 0, key_stop = 0, ser_run = 0, opt_run = 0;
    logic        key_jog = 0, key_rev = 0;
    logic [4:0]  sel_step;
    logic        run_fwd, run_rev, three_wire;
    int          mismatches = 0, n_checks = 0, cyc = 0;
    // Clock and hang guard
    initial forever #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            final_report();
        end
    end
    ssr_contact_model #(.HOLD_CYC(HOLD)) ssr_contact_model_i (.clk_sys_i(clk_sys_i),
        .run_req_i(run_req), .run_lvl_i(run_lvl), .stop_lvl_i(stop_lvl),
        .forward_run_pin_o(fwd_pin), .reverse_stop_pin_o(rev_pin));
    ssr_cmd_select ssr_cmd_select_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .par_wr_i(par_wr), .par_addr_i(par_addr), .par_wdata_i(par_wdata),
        .par_rdata_o(par_rdata), .initialize_select_i(init_sel),
        .forward_run_pin_i(fwd_pin), .reverse_stop_pin_i(rev_pin), .mf_pin_i(mf),
        .first_analog_input_i(a1), .second_analog_input_i(a2), .third_analog_input_i(a3),
        .key_run_i(key_run), .key_stop_i(key_stop), .key_jog_i(key_jog), .key_rev_i(key_rev),
        .serial_run_i(ser_run), .serial_rev_i(1'b0), .option_run_i(opt_run),
        .option_rev_i(1'b0), .sel_freq_o(sel_freq), .sel_step_o(sel_step),
        .run_fwd_o(run_fwd), .run_rev_o(run_rev), .three_wire_o(three_wire));
    task automatic final_report();
        if (mismatches == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        par_wr = 1;
        par_addr = addr;
        par_wdata = data;
        tick(1);
        par_wr = 0;
        tick(1);
    endtask
    task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
        par_addr = addr;
        tick(2);
        chk(par_rdata, exp);
    endtask
    // Drive the factory step and jog inputs, then let the selection settle
    task automatic set_step(input logic [2:0] i, input logic jog);
        // Factory slots: 2, 3 and 6 carry the steps, 4 carries jog
        mf = {3'h0, i[2], 1'b0, jog, i[1], i[0], 2'h0};
        tick(2);
    endtask
    // Factory values and refused writes
    task automatic t_settings();
        rd(16'h0181, 16'h0001);
        rd(16'h0180, 16'h0001);
        rd(16'h0410, 16'h001f);
        wr(16'h0181, 16'h0004);
        rd(16'h0181, 16'h0001);
        wr(16'h0180, 16'h0005);
        rd(16'h0180, 16'h0001);
        wr(16'h0411, 16'h001f);
        rd(16'h0411, 16'h0000);
    endtask
    // Stored references over every step code, then jog priority
    task automatic t_steps();
        for (int i = 0; i < 17; i++)
            wr(16'h0280 + 16'(i), 16'h1000 + 16'(i));
        wr(16'h0180, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            set_step(3'(i), 1'b0);
            chk({11'h0, sel_step}, 16'(i + 1));
            chk(sel_freq, 16'h1000 + 16'(i));
        end
        for (int i = 0; i < 8; i += 7) begin
            set_step(3'(i), 1'b1);
            chk({11'h0, sel_step}, 16'h0009);
            chk(sel_freq, 16'h1010);
        end
    endtask
    // Analog substitution of steps one to three
    task automatic t_analog();
        wr(16'h0180, 16'h0001);
        set_step(3'd0, 1'b0);
        chk(sel_freq, a1);
        wr(16'h0410, 16'h0002);
        set_step(3'd1, 1'b0);
        chk(sel_freq, a3);
        wr(16'h0411, 16'h0003);
        set_step(3'd2, 1'b0);
        chk(sel_freq, a2);
        wr(16'h0411, 16'h0000);
        set_step(3'd2, 1'b0);
        chk(sel_freq, 16'h1002);
        wr(16'h0410, 16'h001f);
        set_step(3'd1, 1'b0);
        chk(sel_freq, 16'h1001);
    endtask
    // Step one moved to another input
    task automatic t_assign();
        wr(16'h0405, 16'h0003);
        wr(16'h0402, 16'h000f);
        mf = 10'h020;
        tick(2);
        chk({11'h0, sel_step}, 16'h0002);
        wr(16'h0402, 16'h0003);
        wr(16'h0405, 16'h000f);
        mf = '0;
    endtask
    // Two-wire levels
    task automatic t_two_wire();
        run_lvl = 1;
        tick(2);
        chk({14'h0, run_fwd, run_rev}, 16'h0002);
        chk({15'h0, three_wire}, 16'h0000);
        stop_lvl = 1;
        tick(2);
        chk({14'h0, run_fwd, run_rev}, 16'h0000);
        run_lvl = 0;
        tick(2);
        chk({14'h0, run_fwd, run_rev}, 16'h0001);
        stop_lvl = 0;
        tick(2);
        chk({14'h0, run_fwd, run_rev}, 16'h0000);
    endtask
    // Three-wire latch, direction and stop
    task automatic t_three_wire();
        init_sel = 1;
        tick(1);
        init_sel = 0;
        tick(2);
        chk({15'h0, three_wire}, 16'h0001);
        stop_lvl = 1;
        run_req = 1;
        tick(1);
        run_req = 0;
        tick(HOLD + 4);
        chk({14'h0, run_fwd, run_rev}, 16'h0002);
        mf[0] = 1;
        tick(2);
        chk({14'h0, run_fwd, run_rev}, 16'h0001);
        stop_lvl = 0;
        tick(2);
        chk({14'h0, run_fwd, run_rev}, 16'h0000);
        mf = '0;
        wr(16'h0400, 16'h000f);
        tick(2);
        chk({15'h0, three_wire}, 16'h0000);
    endtask
    // Keypad, serial and option sources
    task automatic t_sources();
        wr(16'h0181, 16'h0000);
        key_run = 1;
        tick(1);
        key_run = 0;
        tick(3);
        chk({15'h0, run_fwd}, 16'h0001);
        key_stop = 1;
        tick(1);
        key_stop = 0;
        tick(2);
        chk({15'h0, run_fwd}, 16'h0000);
        key_jog = 1;
        key_rev = 1;
        tick(2);
        chk({14'h0, run_fwd, run_rev}, 16'h0001);
        chk({11'h0, sel_step}, 16'h0009);
        key_jog = 0;
        key_rev = 0;
        wr(16'h0181, 16'h0002);
        ser_run = 1;
        tick(2);
        chk({15'h0, run_fwd}, 16'h0001);
        wr(16'h0181, 16'h0003);
        ser_run = 0;
        opt_run = 1;
        tick(2);
        chk({15'h0, run_fwd}, 16'h0001);
        rd(16'h0181, 16'h0003);
        opt_run = 0;
    endtask
    // Mid-run reset returns outputs and settings to their reset values
    task automatic t_reset();
        nrst_i = 0;
        tick(1);
        chk({11'h0, sel_step}, 16'h0001);
        chk({13'h0, run_fwd, run_rev, three_wire}, 16'h0000);
        chk(par_rdata, 16'h0000);
        nrst_i = 1;
        tick(1);
        rd(16'h0181, 16'h0001);
        rd(16'h0180, 16'h0001);
    endtask
    // Main sequence
    initial begin
        tick(20);
        nrst_i = 1;
        tick(1);
        t_settings();
        t_steps();
        t_analog();
        t_assign();
        t_two_wire();
        t_three_wire();
        t_sources();
        t_reset();
        final_report();
    end
endmodule
